// *** dv/rss_flash_model.sv ***
// rss_flash_model: flash module side, answering mass erase and holding the security bytes
`timescale 1ns/1ns
`default_nettype none
module rss_flash_model #(
  parameter logic [15:0] INIT_WORD = 16'hffff
) (
  input wire logic mclk,
  input wire logic [7:0] erase_cyc,
  input wire logic mass_erase_req,
  output logic mass_erase_done,
  output logic [7:0] sec_byte_lo,
  output logic [7:0] sec_byte_hi
);
  // ----------------------------------------
  // erase timing and stored security word
  // ----------------------------------------
  // the security word is programmed last, so it stands whole from the start
  logic [15:0] word_q = INIT_WORD;
  int cnt = 0;

  // erase takes erase_cyc + 1 cycles so the bench can make it prompt or slow
  always @(posedge mclk) begin
    mass_erase_done <= 1'b0;
    if (mass_erase_req !== 1'b1 || mass_erase_done === 1'b1) begin
      cnt <= 0;
    end else if (cnt == int'(erase_cyc)) begin
      mass_erase_done <= 1'b1;
      word_q <= 16'hffff;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // erased cells read all ones, which is not the secure pattern
  assign {sec_byte_hi, sec_byte_lo} = word_q;
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// tb: self-checking bench of the reset sequencer and flash security block
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ----------------------------------------
  // clock, stimulus, design and flash model
  // ----------------------------------------
  logic mclk = 1'b0, rst_b = 1'b0, pin_b = 1'b1, por_b = 1'b1, wdog = 1'b0, ctl_wr = 1'b0;
  logic key_en = 1'b0, key_hit = 1'b0, tck = 1'b0, tms = 1'b1, tdi = 1'b0, trst_b = 1'b0;
  logic stop_d, wait_d, cu, per_b, core_b, run, sec, dbg, mrb, pre, mreq, tdo, done, x;
  logic [7:0] wdata = 8'h00, rdata, lo, hi, d, p, e, ecyc;
  logic [7:0] bsi = 8'h00, bso;
  logic oeb, bdrv;
  logic [6:0] sw_div = 7'h00, div;
  logic [5:0] ratio;
  logic [31:0] o;
  logic [31:0] exp_q[$];
  logic [31:0] got_q[$];
  string nm_q[$];
  int n_fail = 0, n_compared = 0, n;
  wire [4:0] rel = {mreq, run, core_b, per_b, cu};

  always #4 mclk = ~mclk;

  rss_top #(.POR_EXT_CYCLES(40)) dut (.mclk(mclk), .rst_b(rst_b), .ext_reset_pin_b(pin_b),
    .por_b(por_b), .wdog_reset(wdog), .ctl_wr(ctl_wr), .ctl_wdata(wdata), .ctl_rdata(rdata),
    .stop_disable(stop_d), .wait_disable(wait_d), .cu_clk_en(cu), .periph_rst_b(per_b),
    .core_rst_b(core_b), .core_run(run), .sec_byte_lo(lo), .sec_byte_hi(hi),
    .backdoor_key_enable(key_en), .backdoor_key_match(key_hit), .secure_mode(sec),
    .dbg_disable(dbg), .mem_read_block(mrb), .flash_clock_divider_register(sw_div),
    .prescale_by_eight(pre), .div_ratio(ratio), .mass_erase_req(mreq),
    .mass_erase_done(done), .tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b), .tdo(tdo),
    .tdo_oe_b(oeb), .bscan_in(bsi), .bscan_out(bso), .bscan_drive(bdrv));

  rss_flash_model #(.INIT_WORD(rss_pkg::SEC_ON_WORD_DEF)) flash (.mclk(mclk),
    .erase_cyc(ecyc), .mass_erase_req(mreq), .mass_erase_done(done), .sec_byte_lo(lo),
    .sec_byte_hi(hi));

  // ----------------------------------------
  // scoreboard and helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    nm_q.push_back(nm);
    exp_q.push_back(ex);
    got_q.push_back(g);
  endtask

  // each seen result is judged against the oldest note, in order
  always @(posedge mclk) begin
    while (got_q.size() > 0) begin
      n_compared++;
      if (exp_q[0] !== got_q[0]) begin
        n_fail++;
        $display("mismatch %s expected %h seen %h", nm_q[0], exp_q[0], got_q[0]);
      end
      void'(nm_q.pop_front());
      void'(exp_q.pop_front());
      void'(got_q.pop_front());
    end
  end

  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask

  // cycles until a bit of rel (a release output or the erase request) goes high, capped so a stuck output cannot hang us
  task automatic rise(input int s, output int c);
    c = 0;
    while (rel[s] !== 1'b1 && c < 600) begin
      cyc(1);
      c++;
    end
  endtask

  task automatic wr(input logic [7:0] v);
    @(posedge mclk);
    ctl_wr <= 1'b1;
    wdata <= v;
    @(posedge mclk) ctl_wr <= 1'b0;
    cyc(1);
  endtask

  task automatic kp(input logic en);
    @(posedge mclk);
    key_en <= en;
    key_hit <= 1'b1;
    @(posedge mclk) key_hit <= 1'b0;
    cyc(1);
  endtask

  // slow tck: the pins are synchronised, so each phase lasts several mclk
  task automatic jb(input logic m, input logic v, output logic t);
    @(posedge mclk);
    tms <= m;
    tdi <= v;
    cyc(6);
    t = tdo;
    @(posedge mclk) tck <= 1'b1;
    cyc(4);
    @(posedge mclk) tck <= 1'b0;
  endtask

  // shift lsb first through ir or dr, from run-test/idle back to run-test/idle
  task automatic sh(input logic ir, input int len, input logic [31:0] v, output logic [31:0] r);
    logic b, s;
    r = 32'h0;
    jb(1'b1, 1'b0, b);
    if (ir) jb(1'b1, 1'b0, b);
    jb(1'b0, 1'b0, b);
    jb(1'b0, 1'b0, b);
    for (int i = 0; i < len; i++) begin
      jb(i == len - 1, v[i], b);
      r[i] = b;
      if (i == 0) s = oeb;
    end
    jb(1'b1, 1'b0, b);
    jb(1'b0, 1'b0, b);
    chk("tdo_on", 32'h0, s);
    chk("tdo_off", 32'h1, oeb);
  endtask

  task automatic give_verdict();
    repeat (2) @(posedge mclk);
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    n = $urandom(54);
    sw_div = 7'($urandom);
    ecyc = 8'h10 + 8'($urandom % 64);
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    trst_b <= 1'b1;
    bsi <= 8'($urandom);
    rise(0, n);
    chk("por_stretch", 32'h1, 32'(n >= 40 && n <= 48));
    for (int s = 1; s < 4; s++) begin
      rise(s, n);
      chk("window", 32'h20, n);
    end
    chk("secure", 32'h7, {sec, dbg, mrb});
    chk("sw_div", sw_div, {pre, ratio});
    // sleep gating only: the bench has no pll, so software keeps its own clocking
    p = 8'h00;
    for (int i = 0; i < 5; i++) begin
      d = ((8'h01 << i) & 8'h0f) | (8'he0 & 8'($urandom));
      wr(d);
      p = p | (d & 8'h0c);
      e = p | (d & 8'h03);
      chk("ctl", e, rdata);
      chk("gate", {e[3] | e[1], e[2] | e[0]}, {stop_d, wait_d});
    end
    kp(1'b0);
    chk("key_off", 32'h1, sec);
    kp(1'b1);
    chk("key_on", 32'h0, sec);
    @(posedge mclk) wdog <= 1'b1;
    @(posedge mclk) wdog <= 1'b0;
    cyc(1);
    chk("wdog_drop", 32'h0, rel[3:0]);
    rise(0, n);
    chk("no_stretch", 32'h1, 32'(n < 8));
    rise(3, n);
    chk("ctl_clear", 32'h0, rdata);
    chk("resecure", 32'h1, sec);
    wr(8'h10);
    cyc(1);
    chk("sw_rst", 32'h0, core_b);
    rise(3, n);
    jb(1'b0, 1'b0, x);
    sh(1'b1, 4, rss_pkg::IR_IDCODE, o);
    sh(1'b0, 32, 32'h0, o);
    chk("idcode", rss_pkg::IDCODE_DEF, o);
    // boundary scan: capture the pins, then drive a random pattern out
    d = 8'($urandom);
    sh(1'b1, 4, rss_pkg::IR_EXTEST, o);
    sh(1'b0, 8, {24'h000000, d}, o);
    chk("bscan_in", bsi, o);
    chk("bscan_out", {1'b1, d}, {bdrv, bso});
    div = {1'b1, 6'd39 + 6'($urandom % 13)};
    sh(1'b1, 4, rss_pkg::IR_LOCKOUT, o);
    sh(1'b0, 7, div, o);
    rise(4, n);
    chk("erase_go", 32'h1, 32'(n < 8));
    chk("div_override", div, {pre, ratio});
    n = 0;
    // host stays in run-test/idle with tck still until the erase is over
    while (mreq !== 1'b0 && n < 600) begin
      cyc(1);
      n++;
    end
    chk("unsecured", 32'h0, sec);
    @(posedge mclk);
    trst_b <= 1'b0;
    pin_b <= 1'b0;
    cyc(4);
    @(posedge mclk);
    trst_b <= 1'b1;
    pin_b <= 1'b1;
    rise(3, n);
    chk("erased_boot", 32'h0, sec);
    chk("div_back", sw_div, {pre, ratio});
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire

// *** rtl/rss_sync2.sv ***
// rss_sync2: two-flop synchroniser for pins entering the system clock domain
`timescale 1ns/1ns
`default_nettype none
module rss_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // ----------------------------------------
  // the first stage feeds only the second
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule
`default_nettype wire

// *** rtl/rss_top.sv ***
// rss_top: reset release sequencer, sleep gating, flash security and lockout recovery
`timescale 1ns/1ns
`default_nettype none
module rss_top #(
  parameter int unsigned POR_EXT_CYCLES = rss_pkg::POR_EXT_CYCLES_DEF,
  parameter logic [15:0] SEC_ON_WORD = rss_pkg::SEC_ON_WORD_DEF,
  parameter logic [31:0] IDCODE_VALUE = rss_pkg::IDCODE_DEF
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ext_reset_pin_b,
  input wire logic por_b,
  input wire logic wdog_reset,
  input wire logic ctl_wr,
  input wire logic [7:0] ctl_wdata,
  output logic [7:0] ctl_rdata,
  output logic stop_disable,
  output logic wait_disable,
  output logic cu_clk_en,
  output logic periph_rst_b,
  output logic core_rst_b,
  output logic core_run,
  input wire logic [7:0] sec_byte_lo,
  input wire logic [7:0] sec_byte_hi,
  input wire logic backdoor_key_enable,
  input wire logic backdoor_key_match,
  output logic secure_mode,
  output logic dbg_disable,
  output logic mem_read_block,
  input wire logic [6:0] flash_clock_divider_register,
  output logic prescale_by_eight,
  output logic [5:0] div_ratio,
  output logic mass_erase_req,
  input wire logic mass_erase_done,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_b,
  output logic tdo,
  output logic tdo_oe_b,
  input wire logic [7:0] bscan_in,
  output logic [7:0] bscan_out,
  output logic bscan_drive
);

  logic ext_s, por_s, tck_s, tms_s, tdi_s, trst_s;
  logic [7:0] bsi_s;
  logic [21:0] por_last, win_last;
  logic sys_rst_req, tck_rise, tck_fall;
  rss_pkg::rss_seq_t seq_q, seq_d;
  logic [21:0] cnt_q, cnt_d;
  logic porf_q, porf_d, cu_q, cu_d, per_q, per_d, cor_q, cor_d, run_q, run_d;
  logic [7:0] ctl_q, ctl_d;
  logic sw_rst_q, sw_rst_d, stop_q, stop_d, wait_q, wait_d;
  logic sec_q, sec_d, unsec_q, unsec_d, eff_q, eff_d;
  rss_pkg::rss_tap_t tap_q, tap_d, tap_nx;
  logic [3:0] ir_q, ir_d, irsh_q, irsh_d;
  logic [31:0] dr_q, dr_d;
  logic [4:0] dr_msb;
  logic [6:0] div_q, div_d;
  logic [7:0] bsr_q, bsr_d;
  logic divld_q, divld_d, busy_q, busy_d, tckp_q;
  logic tdo_q, tdo_d, oeb_q, oeb_d, bdrv_q, bdrv_d;
  logic [6:0] fdiv_q, fdiv_d;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  rss_sync2 #(.W(6), .INIT(rss_pkg::PIN_SYNC_INIT)) u_pin_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .d({trst_b, tdi, tms, tck, por_b, ext_reset_pin_b}),
    .q({trst_s, tdi_s, tms_s, tck_s, por_s, ext_s})
  );

  rss_sync2 #(.W(8), .INIT(rss_pkg::BSR_RESET)) u_bsi_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .d(bscan_in),
    .q(bsi_s)
  );

  assign por_last = 22'(POR_EXT_CYCLES - 1);
  assign win_last = 22'(rss_pkg::WINDOW_CYCLES - 1);

  // ----------------------------------------
  // reset release sequencer
  // ----------------------------------------
  // pin and power-on sources arrive synchronised, so the sequencer itself adds
  // one cycle of latency to their assertion; release is always clocked
  assign sys_rst_req = !ext_s || !por_s || sw_rst_q || wdog_reset;

  always_comb begin
    seq_d = seq_q;
    cnt_d = cnt_q + rss_pkg::SEQ_CNT_ONE;
    porf_d = porf_q || !por_s;
    if (sys_rst_req) begin
      seq_d = rss_pkg::SEQ_HOLD;
      cnt_d = rss_pkg::SEQ_CNT_ZERO;
    end else begin
      case (seq_q)
        rss_pkg::SEQ_HOLD: begin
          cnt_d = rss_pkg::SEQ_CNT_ZERO;
          seq_d = porf_q ? rss_pkg::SEQ_POR : rss_pkg::SEQ_CLK;
        end
        rss_pkg::SEQ_POR: begin
          if (cnt_q == por_last) begin
            seq_d = rss_pkg::SEQ_CLK;
            cnt_d = rss_pkg::SEQ_CNT_ZERO;
            porf_d = 1'b0;
          end
        end
        rss_pkg::SEQ_CLK: begin
          if (cnt_q == win_last) begin
            seq_d = rss_pkg::SEQ_PER;
            cnt_d = rss_pkg::SEQ_CNT_ZERO;
          end
        end
        rss_pkg::SEQ_PER: begin
          if (cnt_q == win_last) begin
            seq_d = rss_pkg::SEQ_CORE;
            cnt_d = rss_pkg::SEQ_CNT_ZERO;
          end
        end
        rss_pkg::SEQ_CORE: begin
          if (cnt_q == win_last) begin
            seq_d = rss_pkg::SEQ_RUN;
            cnt_d = rss_pkg::SEQ_CNT_ZERO;
          end
        end
        rss_pkg::SEQ_RUN: cnt_d = cnt_q;
        default: seq_d = rss_pkg::SEQ_HOLD;
      endcase
    end
    // each release output is a flop decoded from the next state
    cu_d = (seq_d != rss_pkg::SEQ_HOLD) && (seq_d != rss_pkg::SEQ_POR);
    per_d = (seq_d == rss_pkg::SEQ_PER) || (seq_d == rss_pkg::SEQ_CORE)
      || (seq_d == rss_pkg::SEQ_RUN);
    cor_d = (seq_d == rss_pkg::SEQ_CORE) || (seq_d == rss_pkg::SEQ_RUN);
    run_d = (seq_d == rss_pkg::SEQ_RUN);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      seq_q <= rss_pkg::SEQ_HOLD;
      cnt_q <= rss_pkg::SEQ_CNT_ZERO;
      porf_q <= 1'b1; // own reset counts as power-on
      cu_q <= 1'b0;
      per_q <= 1'b0;
      cor_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
      cnt_q <= cnt_d;
      porf_q <= porf_d;
      cu_q <= cu_d;
      per_q <= per_d;
      cor_q <= cor_d;
      run_q <= run_d;
    end
  end

  // ----------------------------------------
  // system control word: sleep gating and software reset
  // ----------------------------------------
  // permanent bits can only be set; any system reset clears them
  always_comb begin
    ctl_d = ctl_q;
    sw_rst_d = 1'b0;
    if (sys_rst_req) begin
      ctl_d = rss_pkg::CTL_RESET;
    end else if (ctl_wr && run_q) begin
      ctl_d = (ctl_wdata & rss_pkg::CTL_KEEP_MASK)
        | (ctl_q & (8'h01 << rss_pkg::CTL_WAIT_PERM))
        | (ctl_q & (8'h01 << rss_pkg::CTL_STOP_PERM));
      sw_rst_d = ctl_wdata[rss_pkg::CTL_SW_RST];
    end
    stop_d = ctl_d[rss_pkg::CTL_STOP_TMP] || ctl_d[rss_pkg::CTL_STOP_PERM];
    wait_d = ctl_d[rss_pkg::CTL_WAIT_TMP] || ctl_d[rss_pkg::CTL_WAIT_PERM];
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctl_q <= rss_pkg::CTL_RESET;
      sw_rst_q <= 1'b0;
      stop_q <= 1'b0;
      wait_q <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      sw_rst_q <= sw_rst_d;
      stop_q <= stop_d;
      wait_q <= wait_d;
    end
  end

  // ----------------------------------------
  // security state
  // ----------------------------------------
  // fail safe: secure until the bytes are sampled at peripheral release
  always_comb begin
    sec_d = sec_q;
    unsec_d = unsec_q;
    if (seq_q == rss_pkg::SEQ_CLK && seq_d == rss_pkg::SEQ_PER) begin
      sec_d = ({sec_byte_hi, sec_byte_lo} == SEC_ON_WORD);
    end
    if (sys_rst_req) begin
      unsec_d = 1'b0;
    end
    if (backdoor_key_enable && backdoor_key_match && run_q) begin
      unsec_d = 1'b1;
    end
    if (mass_erase_done && busy_q) begin
      unsec_d = 1'b1;
    end
    eff_d = sec_d && !unsec_d;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sec_q <= 1'b1;
      unsec_q <= 1'b0;
      eff_q <= 1'b1;
    end else begin
      sec_q <= sec_d;
      unsec_q <= unsec_d;
      eff_q <= eff_d;
    end
  end

  // ----------------------------------------
  // test access port, sampled on the system clock
  // ----------------------------------------
  // tck must stay below a quarter of mclk for edge detection to hold
  assign tck_rise = tck_s && !tckp_q;
  assign tck_fall = !tck_s && tckp_q;

  always_comb begin
    case (tap_q)
      rss_pkg::TAP_TLR: tap_nx = tms_s ? rss_pkg::TAP_TLR : rss_pkg::TAP_RTI;
      rss_pkg::TAP_RTI: tap_nx = tms_s ? rss_pkg::TAP_SDS : rss_pkg::TAP_RTI;
      rss_pkg::TAP_SDS: tap_nx = tms_s ? rss_pkg::TAP_SIS : rss_pkg::TAP_CDR;
      rss_pkg::TAP_CDR: tap_nx = tms_s ? rss_pkg::TAP_E1DR : rss_pkg::TAP_SHDR;
      rss_pkg::TAP_SHDR: tap_nx = tms_s ? rss_pkg::TAP_E1DR : rss_pkg::TAP_SHDR;
      rss_pkg::TAP_E1DR: tap_nx = tms_s ? rss_pkg::TAP_UDR : rss_pkg::TAP_PDR;
      rss_pkg::TAP_PDR: tap_nx = tms_s ? rss_pkg::TAP_E2DR : rss_pkg::TAP_PDR;
      rss_pkg::TAP_E2DR: tap_nx = tms_s ? rss_pkg::TAP_UDR : rss_pkg::TAP_SHDR;
      rss_pkg::TAP_UDR: tap_nx = tms_s ? rss_pkg::TAP_SDS : rss_pkg::TAP_RTI;
      rss_pkg::TAP_SIS: tap_nx = tms_s ? rss_pkg::TAP_TLR : rss_pkg::TAP_CIR;
      rss_pkg::TAP_CIR: tap_nx = tms_s ? rss_pkg::TAP_E1IR : rss_pkg::TAP_SHIR;
      rss_pkg::TAP_SHIR: tap_nx = tms_s ? rss_pkg::TAP_E1IR : rss_pkg::TAP_SHIR;
      rss_pkg::TAP_E1IR: tap_nx = tms_s ? rss_pkg::TAP_UIR : rss_pkg::TAP_PIR;
      rss_pkg::TAP_PIR: tap_nx = tms_s ? rss_pkg::TAP_E2IR : rss_pkg::TAP_PIR;
      rss_pkg::TAP_E2IR: tap_nx = tms_s ? rss_pkg::TAP_UIR : rss_pkg::TAP_SHIR;
      rss_pkg::TAP_UIR: tap_nx = tms_s ? rss_pkg::TAP_SDS : rss_pkg::TAP_RTI;
      default: tap_nx = rss_pkg::TAP_TLR;
    endcase
  end

  // data register length follows the current instruction
  always_comb begin
    case (ir_q)
      rss_pkg::IR_IDCODE: dr_msb = rss_pkg::DR_MSB_ID;
      rss_pkg::IR_SAMPLE, rss_pkg::IR_EXTEST: dr_msb = rss_pkg::DR_MSB_BSR;
      rss_pkg::IR_LOCKOUT: dr_msb = rss_pkg::DR_MSB_DIV;
      default: dr_msb = rss_pkg::DR_MSB_BYP;
    endcase
  end

  always_comb begin
    tap_d = tap_q;
    ir_d = ir_q;
    irsh_d = irsh_q;
    dr_d = dr_q;
    div_d = div_q;
    divld_d = divld_q;
    bsr_d = bsr_q;
    busy_d = busy_q;
    tdo_d = tdo_q;
    oeb_d = oeb_q;
    if (mass_erase_done) begin
      busy_d = 1'b0;
    end
    if (!trst_s) begin
      tap_d = rss_pkg::TAP_TLR;
      ir_d = rss_pkg::IR_IDCODE;
      divld_d = 1'b0;
      oeb_d = 1'b1;
    end else if (tck_rise) begin
      tap_d = tap_nx;
      case (tap_q)
        rss_pkg::TAP_TLR: begin
          ir_d = rss_pkg::IR_IDCODE;
          divld_d = 1'b0;
        end
        rss_pkg::TAP_CIR: irsh_d = rss_pkg::IR_CAPTURE;
        rss_pkg::TAP_SHIR: irsh_d = {tdi_s, irsh_q[3:1]};
        rss_pkg::TAP_UIR: ir_d = irsh_q;
        rss_pkg::TAP_CDR: begin
          case (ir_q)
            rss_pkg::IR_IDCODE: dr_d = IDCODE_VALUE;
            rss_pkg::IR_SAMPLE, rss_pkg::IR_EXTEST: dr_d = {24'h000000, bsi_s};
            rss_pkg::IR_LOCKOUT: dr_d = {25'h0000000, div_q};
            default: dr_d = 32'h00000000;
          endcase
        end
        rss_pkg::TAP_SHDR: begin
          dr_d = dr_q >> 1;
          dr_d[dr_msb] = tdi_s;
        end
        rss_pkg::TAP_UDR: begin
          if (ir_q == rss_pkg::IR_LOCKOUT) begin
            div_d = dr_q[6:0];
            divld_d = 1'b1;
          end
          if (ir_q == rss_pkg::IR_EXTEST) begin
            bsr_d = dr_q[7:0];
          end
        end
        default: ;
      endcase
      // erase starts on entry into run-test/idle once the divider is loaded
      if (tap_nx == rss_pkg::TAP_RTI && tap_q != rss_pkg::TAP_RTI
          && ir_q == rss_pkg::IR_LOCKOUT && divld_d) begin
        busy_d = 1'b1;
      end
    end else if (tck_fall) begin
      tdo_d = (tap_q == rss_pkg::TAP_SHIR) ? irsh_q[0] : dr_q[0];
      oeb_d = !(tap_q == rss_pkg::TAP_SHIR || tap_q == rss_pkg::TAP_SHDR);
    end
    bdrv_d = (ir_d == rss_pkg::IR_EXTEST);
    // once loaded, the recovery divider replaces the software divider while selected and while the erase runs
    fdiv_d = ((ir_d == rss_pkg::IR_LOCKOUT && divld_d) || busy_d) ? div_d
      : flash_clock_divider_register;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tap_q <= rss_pkg::TAP_TLR;
      ir_q <= rss_pkg::IR_IDCODE;
      irsh_q <= rss_pkg::IR_CAPTURE;
      dr_q <= 32'h00000000;
      div_q <= rss_pkg::DIV_RESET;
      divld_q <= 1'b0;
      bsr_q <= rss_pkg::BSR_RESET;
      busy_q <= 1'b0;
      tckp_q <= 1'b0;
      tdo_q <= 1'b0;
      oeb_q <= 1'b1;
      bdrv_q <= 1'b0;
      fdiv_q <= rss_pkg::DIV_RESET;
    end else begin
      tap_q <= tap_d;
      ir_q <= ir_d;
      irsh_q <= irsh_d;
      dr_q <= dr_d;
      div_q <= div_d;
      divld_q <= divld_d;
      bsr_q <= bsr_d;
      busy_q <= busy_d;
      tckp_q <= tck_s;
      tdo_q <= tdo_d;
      oeb_q <= oeb_d;
      bdrv_q <= bdrv_d;
      fdiv_q <= fdiv_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign ctl_rdata = ctl_q;
  assign stop_disable = stop_q;
  assign wait_disable = wait_q;
  assign cu_clk_en = cu_q;
  assign periph_rst_b = per_q;
  assign core_rst_b = cor_q;
  assign core_run = run_q;
  assign secure_mode = eff_q;
  assign dbg_disable = eff_q;
  assign mem_read_block = eff_q;
  assign prescale_by_eight = fdiv_q[rss_pkg::DIV_PRESCALE_BIT];
  assign div_ratio = fdiv_q[5:0];
  assign mass_erase_req = busy_q;
  assign tdo = tdo_q;
  assign tdo_oe_b = oeb_q;
  assign bscan_out = bsr_q;
  assign bscan_drive = bdrv_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  logic dr_lsb;
  assign dr_lsb = dr_q[0];

  seq_clk_win_a: assert property (disable iff (!rst_b || sys_rst_req)
    $rose(cu_q) |-> ##32 $rose(per_q)) else $error("peripheral release not 32 after clock");
  seq_core_win_a: assert property (disable iff (!rst_b || sys_rst_req)
    $rose(per_q) |-> ##32 $rose(cor_q) ##32 $rose(run_q))
    else $error("core windows not 32 clocks");
  por_extend_a: assert property ($rose(cu_q) && $past(seq_q) == rss_pkg::SEQ_POR
    |-> $past(cnt_q) == por_last) else $error("power-on extension wrong length");
  src_hold_a: assert property (sys_rst_req |=> !cu_q && !per_q && !cor_q && !run_q)
    else $error("reset source did not hold blocks");
  sw_reset_a: assert property (ctl_wr && run_q && ctl_wdata[rss_pkg::CTL_SW_RST]
    |=> ##1 !cor_q && !run_q) else $error("software reset not taken");
  perm_stop_a: assert property (ctl_q[rss_pkg::CTL_STOP_PERM] && !sys_rst_req
    |=> stop_q) else $error("permanent stop disable lost");
  sec_sample_a: assert property ($rose(per_q) && !$past(mass_erase_done)
    |-> eff_q == ($past({sec_byte_hi, sec_byte_lo}) == SEC_ON_WORD))
    else $error("security not taken from bytes");
  key_gate_a: assert property (eff_q && !backdoor_key_enable && !mass_erase_done
    && seq_q == rss_pkg::SEQ_RUN && !sys_rst_req |=> eff_q && dbg_disable)
    else $error("unlocked without key enable");
  erase_go_a: assert property (tck_rise && trst_s && tap_q == rss_pkg::TAP_UDR
    && !tms_s && ir_q == rss_pkg::IR_LOCKOUT && !mass_erase_done |=> mass_erase_req)
    else $error("erase not started on run-test/idle");
  div_ovr_a: assert property (mass_erase_req && $stable(div_q)
    |-> {prescale_by_eight, div_ratio} == div_q) else $error("recovery divider not applied");
  tdo_drv_a: assert property (tck_fall && trst_s && tap_q == rss_pkg::TAP_SHDR
    |=> !tdo_oe_b && tdo == $past(dr_lsb)) else $error("tdo not driven in shift");

  por_done_c: cover property (seq_q == rss_pkg::SEQ_POR ##1 seq_q == rss_pkg::SEQ_CLK);
  erase_c: cover property ($rose(mass_erase_req) ##[1:200] $fell(mass_erase_req));
  backdoor_c: cover property ($fell(eff_q) && backdoor_key_enable);

endmodule
`default_nettype wire

// *** shared/rss_pkg.sv ***
// rss_pkg: constants and types of the reset sequencer and flash security block
package rss_pkg;

  // ----------------------------------------
  // reset sequence timing
  // ----------------------------------------
  localparam int unsigned POR_EXT_CYCLES_DEF = 2097152; // two to the 21
  localparam int unsigned WINDOW_CYCLES = 32;
  localparam logic [21:0] SEQ_CNT_ZERO = 22'h000000;
  localparam logic [21:0] SEQ_CNT_ONE = 22'h000001;

  // ----------------------------------------
  // control word fields and reset values
  // ----------------------------------------
  localparam int CTL_WAIT_TMP = 0;
  localparam int CTL_STOP_TMP = 1;
  localparam int CTL_WAIT_PERM = 2;
  localparam int CTL_STOP_PERM = 3;
  localparam int CTL_SW_RST = 4;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_KEEP_MASK = 8'h0f; // bits that are stored

  // ----------------------------------------
  // security bytes, identity and pin synchroniser reset values
  // ----------------------------------------
  localparam logic [15:0] SEC_ON_WORD_DEF = 16'h5aa5; // arbitrary pattern
  localparam logic [31:0] IDCODE_DEF = 32'h0c0de001; // arbitrary value
  localparam logic [5:0] PIN_SYNC_INIT = 6'h08; // tms high, rest low
  localparam logic [7:0] BSR_RESET = 8'h00;

  // ----------------------------------------
  // test access port instructions and register sizes
  // ----------------------------------------
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_IDCODE = 4'h2;
  localparam logic [3:0] IR_SAMPLE = 4'h3;
  localparam logic [3:0] IR_LOCKOUT = 4'h8;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [4:0] DR_MSB_ID = 5'h1f;
  localparam logic [4:0] DR_MSB_BSR = 5'h07;
  localparam logic [4:0] DR_MSB_DIV = 5'h06;
  localparam logic [4:0] DR_MSB_BYP = 5'h00;
  localparam int DIV_PRESCALE_BIT = 6;
  localparam logic [6:0] DIV_RESET = 7'h00;

  typedef enum logic [2:0] {
    SEQ_HOLD = 3'b000,
    SEQ_POR = 3'b001,
    SEQ_CLK = 3'b010,
    SEQ_PER = 3'b011,
    SEQ_CORE = 3'b100,
    SEQ_RUN = 3'b101
  } rss_seq_t;

  typedef enum logic [3:0] {
    TAP_TLR = 4'b0000, TAP_RTI = 4'b0001, TAP_SDS = 4'b0010, TAP_CDR = 4'b0011,
    TAP_SHDR = 4'b0100, TAP_E1DR = 4'b0101, TAP_PDR = 4'b0110, TAP_E2DR = 4'b0111,
    TAP_UDR = 4'b1000, TAP_SIS = 4'b1001, TAP_CIR = 4'b1010, TAP_SHIR = 4'b1011,
    TAP_E1IR = 4'b1100, TAP_PIR = 4'b1101, TAP_E2IR = 4'b1110, TAP_UIR = 4'b1111
  } rss_tap_t;

endpackage
